// [hdl/odc_rate_ctrl.sv]
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "odc_map.svh"

// Function
// - Every output path runs at the shared output sample rate from the core.
// - Each path has a one-bit oversample select: normal or high performance.
// - Oversample zero: limit 00 gives 3.072 MHz, 01 gives 6.144 MHz.
// - Oversample one: limit 00 and 01 both give 6.144 MHz.
// - Limit 10 gives 12.288 MHz, or 11.2896 MHz for 44.1 kHz family.
// - Rate code 01xxx swaps in 2.8224, 5.6448 and 11.2896 MHz ceilings.
// - No DAC clock ever exceeds the system clock frequency.
// - Limit is only a ceiling; actual clock follows signal conditions below it.
// - Only headphone one, two and earpiece have a clock limit field.
// - PDM speaker clock is 3.072 MHz at oversample zero, 6.144 MHz at one.
// - A 5.6448 MHz-family system clock scales the PDM speaker clock alike.
// - After reset all oversample selects are zero and all limits 00.
// - Normally the DAC runs at 6.144 MHz, or 5.6448 MHz in 44.1 family, or at its ceiling where that is lower.
// - Earpiece register holds its limit at bits 15:14 and select at 13.
module odc_rate_ctrl
(
   // Clock and reset.
   input  wire  logic                 hclk,
   input  wire  logic                 hresetn,
   // AHB-Lite slave.
   input  wire  logic                 hsel,
   input  wire  logic [31:0]          haddr,
   input  wire  logic [1:0]           htrans,
   input  wire  logic                 hwrite,
   input  wire  logic [2:0]           hsize,
   input  wire  logic [31:0]          hwdata,
   input  wire  logic                 hready,
   output logic                       hreadyout,
   output logic [31:0]                hrdata,
   output logic                       hresp,
   // Clocking context from the digital core, same clock domain.
   input  wire  logic [4:0]           sample_rate_code,
   input  wire  logic                 clock_family_select,
   input  wire  odc_pkg::odc_freq_t   main_system_clock_hz,
   input  wire  logic [2:0]           dac_boost_request,
   // Clock-rate results.
   output odc_pkg::odc_clk_out_t      clk_out
);
   import odc_pkg::*;

   localparam odc_reg_t PATH_REG [`ODC_NPATH] =
      '{ODC_R_HP1, ODC_R_HP2, ODC_R_EP};

   odc_state_t          s_q;
   odc_state_t          s_d;
   logic                acc_ok;
   odc_reg_t            wr_reg;
   odc_reg_t            rd_reg;
   logic [31:0]         rd_val;
   logic                fam44;
   odc_freq_t           norm_f;
   odc_freq_t           cap_f;

   // Maps a byte offset to the register it selects.
   function automatic odc_reg_t odc_decode(input logic [`ODC_AW-1:0] a);
      case (a)
         `ODC_OFS_HP1:  odc_decode = ODC_R_HP1;
         `ODC_OFS_HP2:  odc_decode = ODC_R_HP2;
         `ODC_OFS_EP:   odc_decode = ODC_R_EP;
         `ODC_OFS_SPK:  odc_decode = ODC_R_SPK;
         `ODC_OFS_PDM:  odc_decode = ODC_R_PDM;
         `ODC_OFS_STAT: odc_decode = ODC_R_STAT;
         default:       odc_decode = ODC_R_NONE;
      endcase
   endfunction : odc_decode

   // Converts oversample select and limit code to a clock ceiling.
   // The reserved code falls back to the normal ceiling, 6.144 MHz, or 5.6448 MHz in the 44.1 kHz family.
   function automatic odc_freq_t odc_ceiling(input logic       osr,
                                             input logic [1:0] lim,
                                             input logic       f44);
      odc_freq_t f;
      f = f44 ? `ODC_F_5M6448 : `ODC_F_6M144;
      case (lim)
         `ODC_LIM_LOW:
         begin
            if (!osr)
               f = f44 ? `ODC_F_2M8224 : `ODC_F_3M072;
         end
         `ODC_LIM_HIGH:
         begin
            f = f44 ? `ODC_F_11M2896 : `ODC_F_12M288;
         end
         default:
         begin
            f = f;
         end
      endcase
      odc_ceiling = f;
   endfunction : odc_ceiling

   function automatic odc_freq_t odc_min(input odc_freq_t a,
                                         input odc_freq_t b);
      odc_min = (a < b) ? a : b;
   endfunction : odc_min

   always_comb
   begin
      s_d    = s_q;
      rd_val = `ODC_WORD_RST;
      cap_f  = '0;
      norm_f = '0;
      acc_ok = hsel && hready && htrans[1];
      wr_reg = odc_decode(s_q.wr_addr);
      rd_reg = odc_decode(haddr[`ODC_AW-1:0]);
      fam44  = (sample_rate_code[`ODC_FAM_HI:`ODC_FAM_LO] == `ODC_FAM_PAT);

      // Data phase of a write lands in the addressed register.
      if (s_q.wr_pend)
      begin
         for (int i = 0; i < `ODC_NPATH; i++)
         begin
            if (wr_reg == PATH_REG[i])
            begin
               s_d.lim[i] = hwdata[`ODC_LIM_HI:`ODC_LIM_LO];
               s_d.osr[i] = hwdata[`ODC_OSR_BIT];
            end
         end
         if (wr_reg == ODC_R_SPK)
            s_d.spk_osr = hwdata[`ODC_OSR_BIT];
         if (wr_reg == ODC_R_PDM)
            s_d.pdm_osr = hwdata[`ODC_OSR_BIT];
      end

      // Address phase. Read data is taken from the post-write values so
      // that a read right behind a write sees the new contents.
      s_d.wr_pend = acc_ok && hwrite;
      s_d.wr_addr = haddr[`ODC_AW-1:0];
      for (int i = 0; i < `ODC_NPATH; i++)
      begin
         if (rd_reg == PATH_REG[i])
         begin
            rd_val[`ODC_LIM_HI:`ODC_LIM_LO] = s_d.lim[i];
            rd_val[`ODC_OSR_BIT]            = s_d.osr[i];
         end
      end
      if (rd_reg == ODC_R_SPK)
         rd_val[`ODC_OSR_BIT] = s_d.spk_osr;
      if (rd_reg == ODC_R_PDM)
         rd_val[`ODC_OSR_BIT] = s_d.pdm_osr;
      if (rd_reg == ODC_R_STAT)
      begin
         for (int i = 0; i < `ODC_NPATH; i++)
            rd_val[`ODC_ST_BOOST_LO + i] = (s_q.dac[i] > s_q.ceil[i] ||
                                            s_q.dac[i] == s_q.ceil[i]) &&
                                           dac_boost_request[i];
         rd_val[`ODC_ST_FAM44]  = fam44;
         rd_val[`ODC_ST_SYSFAM] = clock_family_select;
      end
      if (acc_ok && !hwrite)
         s_d.rdata = rd_val;
      s_d.ready = 1'b1;
      s_d.resp  = 1'b0;

      // Clock ceilings and dynamic DAC clocks for the three limited paths.
      for (int i = 0; i < `ODC_NPATH; i++)
      begin
         cap_f = odc_min(odc_ceiling(s_q.osr[i], s_q.lim[i], fam44),
                         main_system_clock_hz);
         norm_f = odc_min(fam44 ? `ODC_F_5M6448 : `ODC_F_6M144,
                          cap_f);
         s_d.ceil[i] = cap_f;
         s_d.dac[i]  = dac_boost_request[i] ? cap_f : norm_f;
      end

      // PDM speaker clock, scaled by the system clock family.
      if (clock_family_select)
         s_d.pdm = s_q.pdm_osr ? `ODC_F_5M6448 : `ODC_F_2M8224;
      else
         s_d.pdm = s_q.pdm_osr ? `ODC_F_6M144 : `ODC_F_3M072;

      s_d.rate = sample_rate_code;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_q.osr     <= {`ODC_NPATH{`ODC_OSR_RST}};
         s_q.lim     <= {`ODC_NPATH{`ODC_LIM_RST}};
         s_q.spk_osr <= `ODC_OSR_RST;
         s_q.pdm_osr <= `ODC_OSR_RST;
         s_q.ceil    <= {`ODC_NPATH{`ODC_F_3M072}};
         s_q.dac     <= {`ODC_NPATH{`ODC_F_3M072}};
         s_q.pdm     <= `ODC_F_3M072;
         s_q.rate    <= `ODC_RATE_RST;
         s_q.wr_pend <= 1'b0;
         s_q.wr_addr <= '0;
         s_q.rdata   <= `ODC_WORD_RST;
         s_q.ready   <= 1'b1;
         s_q.resp    <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign hreadyout = s_q.ready;
   assign hrdata    = s_q.rdata;
   assign hresp     = s_q.resp;

   assign clk_out.dac_clock_hz              = s_q.dac;
   assign clk_out.dac_ceiling_hz            = s_q.ceil;
   assign clk_out.pdm_speaker_clock_hz      = s_q.pdm;
   assign clk_out.path_sample_rate          = s_q.rate;
   assign clk_out.path_oversample_select    = s_q.osr;
   assign clk_out.speaker_oversample_select = s_q.spk_osr;
   assign clk_out.pdm_oversample_select     = s_q.pdm_osr;

   chk_rate_follows: assert property (
      @(posedge hclk) disable iff (!hresetn)
      hresetn |=> clk_out.path_sample_rate == $past(sample_rate_code))
      else $error("Path sample rate does not follow the core setting.");

   chk_low_ceiling: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (!s_q.osr[0] && s_q.lim[0] == 2'h0 && sample_rate_code[4:3] != 2'h1
       && main_system_clock_hz >= `ODC_F_12M288)
      |=> clk_out.dac_ceiling_hz[0] == `ODC_F_3M072)
      else $error("Low limit code did not give 3.072 MHz.");

   chk_osr_norm_ceil: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (s_q.osr[1] && !s_q.lim[1][1] && sample_rate_code[4:3] != 2'h1
       && main_system_clock_hz >= `ODC_F_12M288)
      |=> clk_out.dac_ceiling_hz[1] == `ODC_F_6M144)
      else $error("High performance low codes did not give 6.144 MHz.");

   chk_high_ceiling: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (s_q.lim[2] == 2'h2 && sample_rate_code[4:3] != 2'h1
       && main_system_clock_hz >= `ODC_F_12M288)
      |=> clk_out.dac_ceiling_hz[2] == `ODC_F_12M288)
      else $error("Limit code 10 did not give 12.288 MHz.");

   chk_fam_ceiling: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (s_q.lim[0] == 2'h2 && sample_rate_code[4:3] == 2'h1
       && main_system_clock_hz >= `ODC_F_12M288)
      |=> clk_out.dac_ceiling_hz[0] == `ODC_F_11M2896)
      else $error("44.1 kHz family did not give 11.2896 MHz.");

   chk_main_system_clock_cap: assert property (
      @(posedge hclk) disable iff (!hresetn)
      hresetn |=> (clk_out.dac_clock_hz[0] <= $past(main_system_clock_hz)) &&
          (clk_out.dac_clock_hz[1] <= $past(main_system_clock_hz)) &&
          (clk_out.dac_clock_hz[2] <= $past(main_system_clock_hz)))
      else $error("DAC clock exceeds the system clock.");

   chk_under_ceiling: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (clk_out.dac_clock_hz[0] <= clk_out.dac_ceiling_hz[0]) &&
      (clk_out.dac_clock_hz[1] <= clk_out.dac_ceiling_hz[1]) &&
      (clk_out.dac_clock_hz[2] <= clk_out.dac_ceiling_hz[2]))
      else $error("DAC clock above its ceiling.");

   chk_boost_follows: assert property (
      @(posedge hclk) disable iff (!hresetn)
      dac_boost_request[1] |=> clk_out.dac_clock_hz[1] ==
                               clk_out.dac_ceiling_hz[1])
      else $error("Boost request did not raise the DAC clock.");

   chk_pdm_base: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (hresetn && !clock_family_select && s_q.pdm_osr)
      |=> clk_out.pdm_speaker_clock_hz == `ODC_F_6M144)
      else $error("PDM speaker clock not 6.144 MHz at oversample one.");

   chk_pdm_scaled: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (hresetn && clock_family_select && !s_q.pdm_osr)
      |=> clk_out.pdm_speaker_clock_hz == `ODC_F_2M8224)
      else $error("PDM speaker clock not scaled for the 44.1 kHz family.");

   chk_reset_fields: assert property (
      @(posedge hclk)
      $rose(hresetn) |-> (s_q.osr == '0 && s_q.lim == '0 && !s_q.pdm_osr))
      else $error("Configuration fields not cleared by reset.");

   chk_normal_clock: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (!dac_boost_request[0] && sample_rate_code[4:3] == 2'h1
       && s_q.lim[0] == 2'h2 && main_system_clock_hz >= `ODC_F_12M288)
      |=> clk_out.dac_clock_hz[0] == `ODC_F_5M6448)
      else $error("Normal DAC clock is not 5.6448 MHz in 44.1 family.");

   chk_write_store: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && s_q.wr_addr == `ODC_OFS_EP)
      |=> s_q.lim[2] == $past(hwdata[`ODC_LIM_HI:`ODC_LIM_LO]) &&
          s_q.osr[2] == $past(hwdata[`ODC_OSR_BIT]))
      else $error("Earpiece field write did not store the value.");

   chk_hp1_store: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && s_q.wr_addr == `ODC_OFS_HP1)
      |=> s_q.osr[0] == $past(hwdata[`ODC_OSR_BIT]))
      else $error("Headphone one oversample select not stored.");

   chk_fam_low_ceil: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (hresetn && !s_q.osr[1] && s_q.lim[1] == `ODC_LIM_LOW
       && sample_rate_code[`ODC_FAM_HI:`ODC_FAM_LO] == `ODC_FAM_PAT
       && main_system_clock_hz >= `ODC_F_12M288)
      |=> clk_out.dac_ceiling_hz[1] == `ODC_F_2M8224)
      else $error("44.1 kHz family low limit did not give 2.8224 MHz.");

   chk_ceiling_cap: assert property (
      @(posedge hclk) disable iff (!hresetn)
      hresetn |=>
         (clk_out.dac_ceiling_hz[0] <= $past(main_system_clock_hz)) &&
         (clk_out.dac_ceiling_hz[1] <= $past(main_system_clock_hz)) &&
         (clk_out.dac_ceiling_hz[2] <= $past(main_system_clock_hz)))
      else $error("DAC clock ceiling exceeds the system clock.");

   chk_spk_no_limit: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && s_q.wr_addr == `ODC_OFS_SPK)
      |=> s_q.lim == $past(s_q.lim) && s_q.osr == $past(s_q.osr))
      else $error("Speaker path write changed a clock limit field.");

   chk_ep_readback: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (hsel && hready && htrans[1] && !hwrite && !s_q.wr_pend
       && haddr[`ODC_AW-1:0] == `ODC_OFS_EP)
      |=> hrdata[`ODC_LIM_HI:`ODC_LIM_LO] == $past(s_q.lim[2]) &&
          hrdata[`ODC_OSR_BIT] == $past(s_q.osr[2]))
      else $error("Earpiece fields did not read back as stored.");

   chk_pdm_low: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (hresetn && !clock_family_select && !s_q.pdm_osr)
      |=> clk_out.pdm_speaker_clock_hz == `ODC_F_3M072)
      else $error("PDM speaker clock not 3.072 MHz at oversample zero.");

   chk_pdm_scaled_hi: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (hresetn && clock_family_select && s_q.pdm_osr)
      |=> clk_out.pdm_speaker_clock_hz == `ODC_F_5M6448)
      else $error("PDM speaker clock not scaled at oversample one.");

endmodule : odc_rate_ctrl
`default_nettype wire

// [inc/odc_map.svh]
`ifndef ODC_MAP_SVH
`define ODC_MAP_SVH

// Register byte offsets within the block's 4 KB window.
`define ODC_AW           12
`define ODC_OFS_HP1      12'h410
`define ODC_OFS_HP2      12'h418
`define ODC_OFS_EP       12'h420
`define ODC_OFS_SPK      12'h428
`define ODC_OFS_PDM      12'h430
`define ODC_OFS_STAT     12'h440

// Field positions inside a path configuration word.
`define ODC_LIM_HI       15
`define ODC_LIM_LO       14
`define ODC_OSR_BIT      13

// Field positions inside the status word.
`define ODC_ST_BOOST_HI  2
`define ODC_ST_BOOST_LO  0
`define ODC_ST_FAM44     3
`define ODC_ST_SYSFAM    4

// Reset values.
`define ODC_LIM_RST      2'h0
`define ODC_OSR_RST      1'h0
`define ODC_RATE_RST     5'h00
`define ODC_WORD_RST     32'h0000_0000

// Limit codes.
`define ODC_LIM_LOW      2'h0
`define ODC_LIM_NORM     2'h1
`define ODC_LIM_HIGH     2'h2

// Sample-rate code prefix that marks the 44.1 kHz family.
`define ODC_FAM_HI       4
`define ODC_FAM_LO       3
`define ODC_FAM_PAT      2'h1

// Frequencies in Hz, 48 kHz family and 44.1 kHz family.
`define ODC_FW           28
`define ODC_F_3M072      28'h02e_e000
`define ODC_F_6M144      28'h05d_c000
`define ODC_F_12M288     28'h0bb_8000
`define ODC_F_2M8224     28'h02b_1100
`define ODC_F_5M6448     28'h056_2200
`define ODC_F_11M2896    28'h0ac_4400

// Number of paths that carry a clock limit field.
`define ODC_NPATH        3

`endif

// [inc/odc_pkg.sv]
`include "odc_map.svh"

package odc_pkg;

   typedef logic [`ODC_FW-1:0] odc_freq_t;

   typedef enum logic [2:0] {
      ODC_R_HP1,
      ODC_R_HP2,
      ODC_R_EP,
      ODC_R_SPK,
      ODC_R_PDM,
      ODC_R_STAT,
      ODC_R_NONE
   } odc_reg_t;

   // Clock-rate results handed to the converters and the PDM interface.
   typedef struct packed {
      odc_freq_t [`ODC_NPATH-1:0] dac_clock_hz;
      odc_freq_t [`ODC_NPATH-1:0] dac_ceiling_hz;
      odc_freq_t                  pdm_speaker_clock_hz;
      logic [4:0]                 path_sample_rate;
      logic [`ODC_NPATH-1:0]      path_oversample_select;
      logic                       speaker_oversample_select;
      logic                       pdm_oversample_select;
   } odc_clk_out_t;

   // Whole state of the control block.
   typedef struct packed {
      logic [`ODC_NPATH-1:0]       osr;
      logic [`ODC_NPATH-1:0][1:0]  lim;
      logic                        spk_osr;
      logic                        pdm_osr;
      odc_freq_t [`ODC_NPATH-1:0]  ceil;
      odc_freq_t [`ODC_NPATH-1:0]  dac;
      odc_freq_t                   pdm;
      logic [4:0]                  rate;
      logic                        wr_pend;
      logic [`ODC_AW-1:0]          wr_addr;
      logic [31:0]                 rdata;
      logic                        ready;
      logic                        resp;
   } odc_state_t;

endpackage : odc_pkg

// [tb/test_output_dac_clock_rate_control.sv]
`timescale 1ns/1ns
`default_nettype none
`include "odc_map.svh"

module test_output_dac_clock_rate_control;
   import odc_pkg::*;

   logic               hclk;
   logic               hresetn;
   logic               hsel;
   logic [31:0]        haddr;
   logic [1:0]         htrans;
   logic               hwrite;
   logic [2:0]         hsize;
   logic [31:0]        hwdata;
   logic               hreadyout;
   logic [31:0]        hrdata;
   logic               hresp;
   logic [4:0]         sample_rate_code;
   logic               clock_family_select;
   odc_freq_t          main_system_clock_hz;
   logic [2:0]         dac_boost_request;
   odc_clk_out_t       clk_out;
   int unsigned        fails;
   int unsigned        checks;
   logic [31:0]        wdat [5];
   logic [4:0]         rate_v;
   logic               fam_v;
   odc_freq_t          sys_v;
   logic [2:0]         boost_v;
   localparam logic [11:0] ofs_tab [5] = '{`ODC_OFS_HP1, `ODC_OFS_HP2,
      `ODC_OFS_EP, `ODC_OFS_SPK, `ODC_OFS_PDM};

   odc_rate_ctrl u_dut
   (
      .hclk                 (hclk),
      .hresetn              (hresetn),
      .hsel                 (hsel),
      .haddr                (haddr),
      .htrans               (htrans),
      .hwrite               (hwrite),
      .hsize                (hsize),
      .hwdata               (hwdata),
      .hready               (hreadyout),
      .hreadyout            (hreadyout),
      .hrdata               (hrdata),
      .hresp                (hresp),
      .sample_rate_code     (sample_rate_code),
      .clock_family_select  (clock_family_select),
      .main_system_clock_hz (main_system_clock_hz),
      .dac_boost_request    (dac_boost_request),
      .clk_out              (clk_out)
   );

   always #25 hclk = ~hclk;

   task automatic wrap_up();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: %s seen %h expected %h",
                  $time, what, seen, exp);
      end
   endtask : chk

   // Waits for an edge with hready high; a stuck bus counts as a mismatch.
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 100)
      begin
         @(posedge hclk);
         n++;
      end
      if (n >= 100)
         chk(32'h0, 32'h1, "bus stuck");
   endtask : wait_ready

   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      wait_ready();
      htrans <= 2'h0;
      if (wr)
         hwdata <= d;
      wait_ready();
      q = hrdata;
      chk({31'h0, hresp}, 32'h0, "hresp");
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
                        input logic [31:0] mask);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q & mask, exp & mask, "read back");
   endtask : rdchk

   function automatic odc_freq_t exp_ceil(input logic osr,
      input logic [1:0] lim, input logic f44, input odc_freq_t sys);
      odc_freq_t c;
      case (lim)
         2'h0: c = osr ? (f44 ? `ODC_F_5M6448 : `ODC_F_6M144)
                       : (f44 ? `ODC_F_2M8224 : `ODC_F_3M072);
         2'h2: c = f44 ? `ODC_F_11M2896 : `ODC_F_12M288;
         default: c = f44 ? `ODC_F_5M6448 : `ODC_F_6M144;
      endcase
      return (c > sys) ? sys : c;
   endfunction : exp_ceil

   task automatic check_outs();
      odc_freq_t c;
      odc_freq_t n;
      logic      f44;
      int        p;
      f44 = (rate_v[4:3] == 2'h1);
      n = f44 ? `ODC_F_5M6448 : `ODC_F_6M144;
      for (p = 0; p < 3; p++)
      begin
         c = exp_ceil(wdat[p][13], wdat[p][15:14], f44, sys_v);
         chk({4'h0, clk_out.dac_ceiling_hz[p]},
             {4'h0, c}, "ceil");
         if (boost_v[p] == 1'b0 && n < c)
            c = n;
         chk({4'h0, clk_out.dac_clock_hz[p]}, {4'h0, c}, "dac");
         chk({31'h0, clk_out.path_oversample_select[p]},
             {31'h0, wdat[p][13]}, "osr");
      end
      c = wdat[4][13] ? (fam_v ? `ODC_F_5M6448 : `ODC_F_6M144)
                      : (fam_v ? `ODC_F_2M8224 : `ODC_F_3M072);
      chk({4'h0, clk_out.pdm_speaker_clock_hz},
          {4'h0, c}, "pdm");
      chk({27'h0, clk_out.path_sample_rate}, {27'h0, rate_v}, "rate");
      chk({31'h0, clk_out.speaker_oversample_select},
          {31'h0, wdat[3][13]}, "spk osr");
      chk({31'h0, clk_out.pdm_oversample_select},
          {31'h0, wdat[4][13]}, "pdm osr");
      for (p = 0; p < 5; p++)
         rdchk(ofs_tab[p], wdat[p],
               p < 3 ? 32'h0000_e000 : 32'h0000_2000);
      rdchk(`ODC_OFS_STAT, {27'h0, fam_v, f44, boost_v}, 32'h0000_001f);
   endtask : check_outs

   task automatic apply();
      int i;
      sample_rate_code <= rate_v;
      clock_family_select <= fam_v;
      main_system_clock_hz <= sys_v;
      dac_boost_request <= boost_v;
      for (i = 0; i < 5; i++)
         wr(ofs_tab[i], wdat[i]);
      repeat (2) @(posedge hclk);
      check_outs();
   endtask : apply

   // Releases reset; every field must come back at its low-power value.
   task automatic post_reset();
      int i;
      hresetn <= 1'b1;
      for (i = 0; i < 5; i++)
         wdat[i] = 32'h0;
      repeat (2) @(posedge hclk);
      check_outs();
   endtask : post_reset

   initial
   begin
      #1_000_000;
      chk(32'h0, 32'h1, "watchdog expired");
      wrap_up();
   end

   initial
   begin
      int k;
      int f;
      int i;
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rate_v = 5'h00;
      fam_v = 1'b0;
      sys_v = 28'h0ff_ffff;
      boost_v = 3'h0;
      sample_rate_code = rate_v;
      clock_family_select = fam_v;
      main_system_clock_hz = sys_v;
      dac_boost_request = boost_v;
      fails = 0;
      checks = 0;
      void'($urandom(32'ha9f9));
      repeat (4) @(posedge hclk);
      post_reset();
      // Every limit code in both oversample modes and both families.
      for (k = 0; k < 8; k++)
         for (f = 0; f < 2; f++)
         begin
            for (i = 0; i < 5; i++)
               wdat[i] = 32'(k) << 13;
            rate_v = f ? 5'h0b : 5'h13;
            fam_v = f[0];
            boost_v = {f[0], ~f[0], k[1]};
            apply();
         end
      for (k = 0; k < 40; k++)
      begin
         for (i = 0; i < 5; i++)
            wdat[i] = $urandom;
         rate_v = 5'($urandom);
         fam_v = 1'($urandom);
         sys_v = 28'($urandom_range(16000000, 2000000));
         boost_v = 3'($urandom);
         apply();
      end
      // Recommended normal and high performance settings.
      for (k = 0; k < 2; k++)
      begin
         wdat[0] = k ? 32'h0000_a000 : 32'h0000_6000;
         wdat[1] = wdat[0];
         wdat[2] = 32'h0000_6000;
         apply();
      end
      wr(12'h414, 32'hffff_ffff);
      rdchk(ofs_tab[0], wdat[0], 32'h0000_e000);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      post_reset();
      wrap_up();
   end

endmodule : test_output_dac_clock_rate_control
`default_nettype wire
